//--- verilog/alss_pkg.sv
package alss_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 8;
  localparam int START_HIGH_LP_NS = 500;
  localparam int START_HIGH_NM_NS = 150;
  localparam int START_TO_BUSY_NS = 30;
  localparam int START_TO_BUSY_CYC =
    (START_TO_BUSY_NS / CLK_NS < 1) ? 1 : START_TO_BUSY_NS / CLK_NS;
  localparam int CONV_BYP_NS = 660;
  localparam int CONV_PGA_NS = 1550;
  localparam int CONV_BYP_CYC = CONV_BYP_NS / CLK_NS;
  localparam int CONV_PGA_CYC = CONV_PGA_NS / CLK_NS;
  localparam logic [7:0] CONV_BYP_CNT = 8'(CONV_BYP_CYC);
  localparam logic [7:0] CONV_PGA_CNT = 8'(CONV_PGA_CYC);

  // ****************************************
  // widths and codes
  // ****************************************
  localparam int RES_W = 14;
  localparam int FRAME_W = 20;
  localparam int PIN_W = 11;
  localparam logic signed [15:0] CODE_MAX = 16'sh1FFF;
  localparam logic signed [15:0] CODE_MIN = 16'shE000;
  localparam logic [2:0] CHAN_FIRST = 3'h0;
  localparam logic [2:0] CHAN_LAST = 3'h7;
  localparam logic [1:0] FALLS_RUN = 2'h2;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] STATUS_OFS = 12'h000;
  localparam logic [11:0] CTRL_OFS = 12'h004;
  localparam logic [11:0] PATTERN_OFS = 12'h008;
  localparam logic CTRL_RST = 1'h0;
  localparam logic [13:0] PATTERN_RST = 14'h0000;
  localparam int CTRL_PAT_BIT = 0;
  localparam int ST_PHASE_LSB = 0;
  localparam int ST_CHAN_LSB = 3;
  localparam int ST_GAIN_LSB = 6;
  localparam int ST_PTR_LSB = 9;
  localparam int ST_SCAN_BIT = 12;
  localparam int ST_INV_BIT = 13;
  localparam int ST_BUSY_BIT = 14;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    PH_ACQUIRE = 3'b001,
    PH_CONVERT = 3'b010,
    PH_READOUT = 3'b100
  } alss_phase_e;

  typedef struct packed {
    logic [2:0] chan;
    logic [2:0] gain;
  } alss_sel_s;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic lp;
    logic scan;
    logic bypass;
    alss_sel_s sel;
  } alss_pins_s;

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] lvl;
  } alss_sync_s;

  typedef struct packed {
    logic [FRAME_W-1:0] word;
  } alss_shift_s;

  typedef struct packed {
    alss_phase_e phase;
    logic cs_d;
    logic sclk_d;
    logic scan_d;
    logic [7:0] conv_cnt;
    logic busy;
    logic oe;
    logic strobe;
    logic invalid;
    logic first;
    alss_sel_s cap;
    alss_sel_s pend;
    alss_sel_s act;
    logic [2:0] ptr;
    logic [1:0] falls;
    logic exit;
    logic pat_en;
    logic [13:0] pattern;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } alss_top_s;

  // saturate a wide signed code into the 14-bit output range
  function automatic logic [RES_W-1:0] alss_clamp(
    input logic signed [15:0] raw
  );
    if (raw > CODE_MAX) begin
      return CODE_MAX[RES_W-1:0];
    end
    if (raw < CODE_MIN) begin
      return CODE_MIN[RES_W-1:0];
    end
    return raw[RES_W-1:0];
  endfunction

endpackage

//--- verilog/alss_sync.sv
`timescale 1ns/10ps
module alss_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [alss_pkg::PIN_W-1:0] pin_in,
  output logic [alss_pkg::PIN_W-1:0] level
);

  alss_pkg::alss_sync_s st_ff;
  alss_pkg::alss_sync_s nxt_st;

  // three stages; level moves only where stage two and three agree
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.lvl = (st_ff.s2 & st_ff.s3) |
                 (st_ff.lvl & (st_ff.s2 | st_ff.s3));
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.lvl;

endmodule

//--- verilog/alss_shift.sv
`timescale 1ns/10ps
module alss_shift (
  input wire logic mclk,
  input wire logic rst,
  input wire logic load,
  input wire logic [alss_pkg::FRAME_W-1:0] load_word,
  input wire logic shift,
  output logic sdo
);

  alss_pkg::alss_shift_s st_ff;
  alss_pkg::alss_shift_s nxt_st;

  // load wins over shift; zeros follow the last tag bit
  always_comb begin
    nxt_st = st_ff;
    if (load) begin
      nxt_st.word = load_word;
    end else if (shift) begin
      nxt_st.word = {st_ff.word[alss_pkg::FRAME_W-2:0], 1'b0};
    end
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sdo = st_ff.word[alss_pkg::FRAME_W-1];

endmodule

//--- verilog/alss_top.sv
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/10ps
// Operation
// - in low power mode convert-start high time is the acquisition time
// - busy rises shortly after convert-start falls, bypassed amplifier
// - bypassed conversion ends within 660ns, then busy falls
// - six channel and gain bits follow the result on extra clocks
// - trailing bits are channel then gain, each msb first
// - channel and gain selects latch on every convert-start rise
// - normal mode applies latched selects one sample later
// - low power mode applies latched selects to the same sample
// - bypass or eight gain codes, host updates gain per sample
// - output code saturates between -8192 and 8191
// - sequencer runs only while scan is asserted
// - normal mode first sample after scan is an initialization cycle
// - pair zero at second fall after scan, rises advance, wrap 7->0
// - low power scan, sample after first rise is invalid
// - channel selects are ignored while scan is asserted
// - in scan, reported channel bits are the sequencer channel
// - after scan drops, next sample is following channel, then pins
// - msb stands on serial output when busy falls, rises shift
// - start fall samples, converts, enables output; high means off
// - low power select low is normal, high is low power
module alss_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [alss_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic convert_start_n,
  input wire logic serial_clock,
  input wire logic low_power_select,
  input wire logic scan_enable,
  input wire logic pga_bypass,
  input wire logic channel_sel_bit2,
  input wire logic channel_sel_bit1,
  input wire logic channel_sel_bit0,
  input wire logic gain_sel_bit2,
  input wire logic gain_sel_bit1,
  input wire logic gain_sel_bit0,
  input wire logic signed [15:0] core_code,
  output logic busy,
  output logic sdo,
  output logic sdo_oe,
  output logic sample_strobe,
  output logic sample_invalid,
  output alss_pkg::alss_sel_s active_sel
);

  // ****************************************
  // pin filtering
  // ****************************************
  alss_pkg::alss_pins_s raw;
  alss_pkg::alss_pins_s pin;
  logic [alss_pkg::PIN_W-1:0] pin_lvl;

  // gather the pins into one word for the filter
  assign raw = {convert_start_n, serial_clock, low_power_select,
                scan_enable, pga_bypass,
                channel_sel_bit2, channel_sel_bit1, channel_sel_bit0,
                gain_sel_bit2, gain_sel_bit1, gain_sel_bit0};
  assign pin = alss_pkg::alss_pins_s'(pin_lvl);

  alss_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_in(raw),
    .level(pin_lvl)
  );

  // ****************************************
  // state and edges
  // ****************************************
  alss_pkg::alss_top_s st_ff;
  alss_pkg::alss_top_s nxt_st;
  alss_pkg::alss_sel_s sel_now;
  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic scan_rise;
  logic scan_fall;
  logic start_ok;
  logic conv_done;
  logic phase_evt;
  logic ld;
  logic sh;
  logic [alss_pkg::FRAME_W-1:0] ld_word;
  logic [alss_pkg::RES_W-1:0] res_code;
  logic res_msb;
  logic [31:0] status_word;
  logic acc_rd;
  logic acc_wr;

  // edge detection on the filtered levels
  assign cs_rise = pin.cs_n & ~st_ff.cs_d;
  assign cs_fall = ~pin.cs_n & st_ff.cs_d;
  assign sclk_rise = pin.sclk & ~st_ff.sclk_d;
  assign scan_rise = pin.scan & ~st_ff.scan_d;
  assign scan_fall = ~pin.scan & st_ff.scan_d;
  assign start_ok = cs_fall & (st_ff.phase != alss_pkg::PH_CONVERT);
  assign conv_done = (st_ff.phase == alss_pkg::PH_CONVERT) &
                     (st_ff.conv_cnt == 8'h01);
  assign phase_evt = cs_rise | cs_fall | conv_done;

  // result code, test pattern or saturated converter output
  assign res_code = st_ff.pat_en ? st_ff.pattern :
                    alss_pkg::alss_clamp(core_code);
  assign res_msb = res_code[alss_pkg::RES_W-1];

  // low power uses this sample's latch, normal the one before
  assign sel_now = pin.lp ? st_ff.cap : st_ff.pend;

  // status view of the sequencer
  always_comb begin
    status_word = 32'h00000000;
    status_word[alss_pkg::ST_PHASE_LSB +: 3] = st_ff.phase;
    status_word[alss_pkg::ST_CHAN_LSB +: 3] = st_ff.act.chan;
    status_word[alss_pkg::ST_GAIN_LSB +: 3] = st_ff.act.gain;
    status_word[alss_pkg::ST_PTR_LSB +: 3] = st_ff.ptr;
    status_word[alss_pkg::ST_SCAN_BIT] = pin.scan;
    status_word[alss_pkg::ST_INV_BIT] = st_ff.invalid;
    status_word[alss_pkg::ST_BUSY_BIT] = st_ff.busy;
  end

  assign acc_rd = psel & penable & ~st_ff.pready;
  assign acc_wr = psel & penable & st_ff.pready & pwrite;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    ld = 1'b0;
    sh = 1'b0;
    ld_word = '0;
    nxt_st.cs_d = pin.cs_n;
    nxt_st.sclk_d = pin.sclk;
    nxt_st.scan_d = pin.scan;
    nxt_st.strobe = 1'b0;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    // output driver follows convert-start level
    nxt_st.oe = ~pin.cs_n;

    // selects latch on every rise, previous latch moves down
    if (cs_rise) begin
      nxt_st.cap = pin.sel;
      nxt_st.pend = st_ff.cap;
      if (pin.scan && st_ff.falls == alss_pkg::FALLS_RUN) begin
        nxt_st.ptr = st_ff.ptr + 3'h1;
      end
      if (st_ff.phase == alss_pkg::PH_READOUT) begin
        nxt_st.phase = alss_pkg::PH_ACQUIRE;
      end
    end

    // sequencer restarts on scan, exit marked on its removal
    if (scan_rise) begin
      nxt_st.ptr = alss_pkg::CHAN_FIRST;
      nxt_st.falls = 2'h0;
      nxt_st.exit = 1'b0;
    end else if (scan_fall) begin
      nxt_st.exit = 1'b1;
    end

    // sampling instant: start conversion and pick channel and gain
    if (start_ok) begin
      nxt_st.phase = alss_pkg::PH_CONVERT;
      nxt_st.busy = 1'b1;
      nxt_st.strobe = 1'b1;
      nxt_st.conv_cnt = pin.bypass ? alss_pkg::CONV_BYP_CNT :
                        alss_pkg::CONV_PGA_CNT;
      ld = 1'b1;
      nxt_st.act.gain = sel_now.gain;
      nxt_st.invalid = st_ff.first & ~pin.lp;
      if (pin.scan) begin
        // channel pins ignored, sequencer owns the mux
        nxt_st.act.chan = st_ff.ptr;
        if (st_ff.falls != alss_pkg::FALLS_RUN) begin
          nxt_st.falls = st_ff.falls + 2'h1;
        end
        if (st_ff.falls == 2'h0 ||
            (st_ff.falls == 2'h1 && !pin.lp)) begin
          nxt_st.invalid = 1'b1;
        end
      end else if (st_ff.exit) begin
        // ptr still names the last scanned pair, step past it
        nxt_st.act.chan = st_ff.ptr + 3'h1;
        nxt_st.exit = 1'b0;
      end else begin
        nxt_st.act.chan = sel_now.chan;
      end
      nxt_st.first = 1'b0;
    end

    // internally timed conversion, result loaded msb first
    if (st_ff.phase == alss_pkg::PH_CONVERT) begin
      if (conv_done) begin
        nxt_st.busy = 1'b0;
        nxt_st.phase = alss_pkg::PH_READOUT;
        ld = 1'b1;
        ld_word = {res_code, st_ff.act.chan, st_ff.act.gain};
      end else begin
        nxt_st.conv_cnt = st_ff.conv_cnt - 8'h01;
      end
    end

    // serial clock rises shift the next bit out
    if (sclk_rise && !pin.cs_n &&
        st_ff.phase == alss_pkg::PH_READOUT && !ld) begin
      sh = 1'b1;
    end

    // register read, one wait state
    if (acc_rd) begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = 32'h00000000;
      case (paddr)
        alss_pkg::STATUS_OFS: begin
          if (!pwrite) begin
            nxt_st.prdata = status_word;
          end
        end
        alss_pkg::CTRL_OFS: begin
          if (!pwrite) begin
            nxt_st.prdata[alss_pkg::CTRL_PAT_BIT] = st_ff.pat_en;
          end
        end
        alss_pkg::PATTERN_OFS: begin
          if (!pwrite) begin
            nxt_st.prdata[13:0] = st_ff.pattern;
          end
        end
        default: begin
          nxt_st.pslverr = 1'b1;
        end
      endcase
    end

    // register write at the completing edge
    if (acc_wr) begin
      case (paddr)
        alss_pkg::CTRL_OFS: begin
          nxt_st.pat_en = pwdata[alss_pkg::CTRL_PAT_BIT];
        end
        alss_pkg::PATTERN_OFS: begin
          nxt_st.pattern = pwdata[13:0];
        end
        default: begin
          nxt_st.pat_en = st_ff.pat_en;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.phase <= alss_pkg::PH_ACQUIRE;
      st_ff.first <= 1'b1;
      st_ff.pat_en <= alss_pkg::CTRL_RST;
      st_ff.pattern <= alss_pkg::PATTERN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // serial output
  // ****************************************
  alss_shift u_shift (
    .mclk(mclk),
    .rst(rst),
    .load(ld),
    .load_word(ld_word),
    .shift(sh),
    .sdo(sdo)
  );

  assign busy = st_ff.busy;
  assign sdo_oe = st_ff.oe;
  assign sample_strobe = st_ff.strobe;
  assign sample_invalid = st_ff.invalid;
  assign active_sel = st_ff.act;
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;

  // ****************************************
  // checks
  // ****************************************
  logic [7:0] busy_len_ff;

  // cycles spent busy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_len_ff <= 8'h00;
    end else if (st_ff.busy) begin
      busy_len_ff <= busy_len_ff + 8'h01;
    end else begin
      busy_len_ff <= 8'h00;
    end
  end

  a_busy_on_fall: assert property (
    @(posedge mclk) disable iff (rst)
    start_ok |=> busy ##0 sample_strobe
  ) else $error("busy not raised at start fall");

  a_conv_bound: assert property (
    @(posedge mclk) disable iff (rst)
    busy |-> busy_len_ff < (pin.bypass ? alss_pkg::CONV_BYP_CNT :
                            alss_pkg::CONV_PGA_CNT)
  ) else $error("conversion ran too long");

  a_msb_at_done: assert property (
    @(posedge mclk) disable iff (rst)
    $fell(busy) |-> sdo == $past(res_msb)
  ) else $error("msb missing when busy falls");

  a_oe_with_cs: assert property (
    @(posedge mclk) disable iff (rst)
    pin.cs_n |=> !sdo_oe
  ) else $error("output driven while start high");

  a_clamp_high: assert property (
    @(posedge mclk) disable iff (rst)
    (core_code > alss_pkg::CODE_MAX && !st_ff.pat_en) |->
      res_code == 14'h1FFF
  ) else $error("positive clamp failed");

  a_scan_chan: assert property (
    @(posedge mclk) disable iff (rst)
    (start_ok && pin.scan) |=> active_sel.chan == $past(st_ff.ptr)
  ) else $error("scan channel not from sequencer");

  a_ptr_wrap: assert property (
    @(posedge mclk) disable iff (rst)
    (cs_rise && pin.scan && !scan_rise &&
     st_ff.falls == alss_pkg::FALLS_RUN &&
     st_ff.ptr == alss_pkg::CHAN_LAST) |=>
      st_ff.ptr == alss_pkg::CHAN_FIRST
  ) else $error("sequencer did not wrap");

  a_lp_same: assert property (
    @(posedge mclk) disable iff (rst)
    (start_ok && pin.lp && !pin.scan && !st_ff.exit) |=>
      active_sel == $past(st_ff.cap)
  ) else $error("low power select not same sample");

  a_nm_delay: assert property (
    @(posedge mclk) disable iff (rst)
    (start_ok && !pin.lp && !pin.scan && !st_ff.exit) |=>
      active_sel == $past(st_ff.pend)
  ) else $error("normal select not one sample late");

  a_scan_gate: assert property (
    @(posedge mclk) disable iff (rst)
    !pin.scan |=> $stable(st_ff.ptr)
  ) else $error("sequencer moved without scan");

  a_phase_step: assert property (
    @(posedge mclk) disable iff (rst)
    $changed(st_ff.phase) |-> $past(phase_evt)
  ) else $error("phase moved without cause");

endmodule

//--- testbench/alss_host_model.sv
`timescale 1ns/10ps
// ********
// host side: convert-start, serial clock and select pins
// ********
module alss_host_model (
  input wire logic mclk,
  input wire logic busy,
  input wire logic sdo,
  output logic cs_n,
  output logic sclk,
  output alss_pkg::alss_sel_s sel
);
  // start low, as at power-up; serial clock idles low between frames
  initial begin
    cs_n = 1'b0;
    sclk = 1'b0;
    sel = 6'h00;
  end

  // one sample cycle: selects, acquisition, conversion, readout
  task automatic run(
    input alss_pkg::alss_sel_s nsel,
    input int hi,
    input int nb,
    output logic [19:0] frm,
    output int dly,
    output int wid
  );
    int i;
    frm = 20'h00000;
    dly = 0;
    @(posedge mclk);
    sel <= nsel;
    repeat (3) @(posedge mclk);
    cs_n <= 1'b1;
    repeat (hi) @(posedge mclk);
    cs_n <= 1'b0;
    do begin
      @(negedge mclk);
      dly++;
    end while (busy !== 1'b1 && dly < 20);
    wid = 1;
    while (busy === 1'b1 && wid < 400) begin
      @(negedge mclk);
      if (busy === 1'b1) wid++;
    end
    // 64 ns serial clock, each rise 3 ns after a system clock fall
    for (i = 0; i < nb; i++) begin
      frm[19-i] = sdo;
      #3 sclk = 1'b1;
      #32 sclk = 1'b0;
      if (i < nb - 1) begin
        #25;
        @(negedge mclk);
      end
    end
  endtask
endmodule

//--- testbench/adc_lowpower_scan_sequencer_tb.sv
`timescale 1ns/10ps
module adc_lowpower_scan_sequencer_tb;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic cs_n, sclk, lp, scan, byp, busy, sdo, sdo_oe, strobe, inval, e;
  logic signed [15:0] code;
  alss_pkg::alss_sel_s sel, act, last_lat;
  logic first, exit_p, pat_en;
  logic [2:0] last_ch;
  logic [13:0] pat;
  int fail_count, n_compared, n_strobe, hi_cnt, k;
  logic [15:0] corner [6] = '{16'h1FFF, 16'h2000, 16'hE000, 16'hDFFF,
                              16'h7FFF, 16'h8000};

  alss_top alss_top_inst (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convert_start_n(cs_n), .serial_clock(sclk), .low_power_select(lp),
    .scan_enable(scan), .pga_bypass(byp),
    .channel_sel_bit2(sel.chan[2]), .channel_sel_bit1(sel.chan[1]),
    .channel_sel_bit0(sel.chan[0]), .gain_sel_bit2(sel.gain[2]),
    .gain_sel_bit1(sel.gain[1]), .gain_sel_bit0(sel.gain[0]),
    .core_code(code), .busy(busy), .sdo(sdo), .sdo_oe(sdo_oe),
    .sample_strobe(strobe), .sample_invalid(inval), .active_sel(act));

  alss_host_model alss_host_model_inst (.mclk(mclk), .busy(busy),
    .sdo(sdo), .cs_n(cs_n), .sclk(sclk), .sel(sel));

  // ********
  // helpers
  // ********
  task automatic wrap_up;
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // saturating 14-bit output code
  function automatic logic [13:0] sat(input logic signed [15:0] v);
    if (v > 16'sh1FFF) return 14'h1FFF;
    if (v < 16'shE000) return 14'h2000;
    return v[13:0];
  endfunction

  // one bus transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(1'b0, 1'b1, "bus hang");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one sample with the expected selects worked out beforehand
  task automatic one(input logic [15:0] c, input int nb);
    alss_pkg::alss_sel_s ns, prev, ex;
    logic [19:0] frm;
    logic inv;
    int dly, wid, s0;
    ns = 6'($urandom);
    @(posedge mclk);
    code <= c;
    prev = last_lat;
    last_lat = ns;
    ex.gain = lp ? ns.gain : prev.gain;
    if (scan) begin
      k++;
      ex.chan = (k >= 2) ? 3'(k - 2) : 3'h0;
      last_ch = ex.chan;
    end else if (exit_p) begin
      ex.chan = last_ch + 3'h1;
      exit_p = 1'b0;
    end else ex.chan = lp ? ns.chan : prev.chan;
    inv = (scan && (k == 1 || (k == 2 && !lp))) || (first && !lp);
    first = 1'b0;
    s0 = n_strobe;
    alss_host_model_inst.run(ns, lp ? 63 + $urandom % 8 : 19 + $urandom % 8,
                             nb, frm, dly, wid);
    chk(dly <= 6, 1'b1, "busy rise late");
    chk(wid, byp ? alss_pkg::CONV_BYP_CYC :
        alss_pkg::CONV_PGA_CYC, "conv");
    chk(inval, inv, "invalid flag");
    chk(n_strobe - s0, 1, "strobe count");
    chk(sdo_oe, 1'b1, "driver on");
    if (!inv) begin
      chk(frm[19:6], pat_en ? pat : sat(c), "result");
      chk(act, ex, "active sel");
      if (nb == 20) chk(frm[5:0], ex, "trailing bits");
    end
  endtask

  // ********
  // clock, monitors, watchdog
  // ********
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(negedge mclk) begin
    if (strobe === 1'b1) n_strobe++;
    hi_cnt = (cs_n === 1'b1) ? hi_cnt + 1 : 0;
    if (hi_cnt > 8) chk(sdo_oe, 1'b0, "driver off");
  end

  initial begin
    #500000;
    fail_count++;
    wrap_up();
  end

  // ********
  // main sequence
  // ********
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {lp, scan, byp, code, pat_en, exit_p} = '0;
    {fail_count, n_compared, n_strobe, hi_cnt, k} = '0;
    last_lat = 6'h00;
    last_ch = 3'h0;
    pat = 14'h0000;
    first = 1'b1;
    rst = 1'b1;
    void'($urandom(21));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    apb(1'b0, alss_pkg::CTRL_OFS, 32'h0);
    chk(r, 32'h0, "ctrl reset");
    apb(1'b0, alss_pkg::PATTERN_OFS, 32'h0);
    chk(r, 32'h0, "pattern reset");
    apb(1'b0, 12'h00C, 32'h0);
    chk(r, 32'h0, "unmapped data");
    chk(e, 1'b1, "unmapped error");
    apb(1'b1, alss_pkg::STATUS_OFS, 32'hFFFFFFFF);
    chk(e, 1'b0, "status write");
    apb(1'b0, alss_pkg::STATUS_OFS, 32'h0);
    chk(r[14:0], 15'h0001, "status idle");
    // sections: mode, amplifier, scan length, total samples
    for (int s = 0; s < 4; s++) begin
      int nsc, tot;
      nsc = (s == 2) ? 10 : (s == 3) ? 4 : 0;
      tot = (s == 0) ? 6 : (s == 1) ? 3 : nsc + 2;
      @(posedge mclk);
      lp <= s[0];
      byp <= (s != 1);
      for (int j = 0; j < tot; j++) begin
        if (nsc > 0 && (j == 0 || j == nsc)) begin
          @(posedge mclk);
          scan <= (j == 0);
          k = 0;
          exit_p = (j != 0);
          repeat (6) @(posedge mclk);
          apb(1'b0, alss_pkg::STATUS_OFS, 32'h0);
          chk(r[12], j == 0, "scan status");
        end
        one(j < 6 ? corner[j] : 16'($urandom), s == 1 ? 14 : 20);
      end
      apb(1'b0, alss_pkg::STATUS_OFS, 32'h0);
      chk(r[2:0], 3'h4, "phase readout");
    end
    apb(1'b1, alss_pkg::PATTERN_OFS, 32'h00002A5C);
    apb(1'b1, alss_pkg::CTRL_OFS, 32'h00000001);
    apb(1'b0, alss_pkg::PATTERN_OFS, 32'h0);
    chk(r, 32'h00002A5C, "pattern readback");
    pat = 14'h2A5C;
    pat_en = 1'b1;
    one(16'h1234, 20);
    wrap_up();
  end
endmodule
